// ### inc/charger_pkg.sv
// Purpose: Shared constants and types of the battery charge sequencer.
// Assumes: A 100 MHz core clock and byte wide registers.
// Notes:   Timing counts are derived from the times given below.
package charger_pkg;

  // Core clock period and the millisecond tick derived from it.
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int MS_CYCLES      = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

  // Charger times, counted in millisecond ticks.
  localparam int RESTART_DELAY_MS = 100;
  localparam int ABSENT_WINDOW_MS = 2000;
  localparam int ABSENT_REPEAT    = 2;
  localparam int MS_CNT_W         = 12;

  // Register offsets.
  localparam logic [7:0] ADDR_TERM_CFG = 8'h10;
  localparam logic [7:0] ADDR_CTRL_A   = 8'h14;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h16;
  localparam logic [7:0] ADDR_STATUS   = 8'h35;

  // Field positions of termination_current_config.
  localparam int TERM_OFS_LSB = 2;

  // Field positions of charger_control_a.
  localparam int CTRL_A_EN       = 0;
  localparam int CTRL_A_FAST_LSB = 1;
  localparam int CTRL_A_PRE_LSB  = 5;
  localparam int CTRL_A_OVP_EN   = 7;

  // Field positions of charger_control_b.
  localparam int CTRL_B_INHIBIT = 3;
  localparam int CTRL_B_CUTOFF  = 4;
  localparam int CTRL_B_OVH     = 6;
  localparam int CTRL_B_OVFLAG  = 7;

  // Field positions of charger_state_flags.
  localparam int STAT_DET     = 0;
  localparam int STAT_ACT     = 1;
  localparam int STAT_TRICKLE = 3;
  localparam int STAT_CV      = 4;
  localparam int STAT_EOC     = 5;
  localparam int STAT_ABSENT  = 6;

  // Reset values of the control fields.
  localparam logic       RST_CHARGE_EN  = 1'b1;
  localparam logic [3:0] RST_FAST_SEL   = 4'h0;
  localparam logic [1:0] RST_PRE_SEL    = 2'h0;
  localparam logic       RST_OVP_EN     = 1'b1;
  localparam logic [1:0] RST_TERM_OFS   = 2'h0;
  localparam logic       RST_INHIBIT    = 1'b0;
  localparam logic       RST_CUTOFF_SEL = 1'b1;
  localparam logic       RST_OVH_SEL    = 1'b1;

  // Current step of both current selections, in mA.
  localparam logic [9:0] CURRENT_STEP_MA = 10'h032;

  // Charger states, Gray coded along the charge path.
  typedef enum logic [2:0] {
    ST_IDLE          = 3'h0,
    ST_PRECHARGE     = 3'h1,
    ST_CONST_CURRENT = 3'h3,
    ST_CONST_VOLTAGE = 3'h2,
    ST_END_OF_CHARGE = 3'h6,
    ST_RESTART_WAIT  = 3'h7
  } chg_state_t;

  // Analog comparator results.
  typedef struct packed {
    logic adapter_present;
    logic batt_below_uvlo;
    logic at_termination;
    logic current_at_precharge;
    logic batt_below_resume;
    logic overvolt;
  } cmp_t;

  // Command to the analog charge regulator.
  typedef struct packed {
    logic [9:0] current_limit_ma;
    logic       regulate_on;
    logic       const_voltage;
    logic       cutoff_voltage_sel;
    logic       overvolt_high_thresh;
    logic [1:0] termination_current_offset;
  } reg_cmd_t;

endpackage : charger_pkg

// ### src/ms_tick_gen.sv
// Purpose: Divides the core clock down to a one-cycle millisecond tick.
// Assumes: CYCLES core clocks make one millisecond.
// Notes:   The tick restarts its period when clear is high.
`timescale 1ns/10ps
module ms_tick_gen #(
  parameter int CYCLES = charger_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic clear,
  // Tick
  output logic      tick
);

  localparam int W = (CYCLES > 2) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count_ff;

  if (CYCLES < 2) begin : g_bad_cycles
    $error("ms_tick_gen needs at least two cycles per tick");
  end

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      count_ff <= '0;
    end else if (count_ff == LAST) begin
      count_ff <= '0;
    end else begin
      count_ff <= count_ff + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      tick <= 1'b0;
    end else begin
      tick <= (count_ff == LAST);
    end
  end

endmodule : ms_tick_gen

// ### src/li_battery_charge_sequencer.sv
// Purpose: Sequences a single cell lithium charger through its phases.
// Assumes: Comparator inputs are asynchronous and are synchronised here.
// Notes:   Registers are reached over a byte wide internal register port.
`timescale 1ns/10ps
// Summary of operation
// RULE1: Adapter flag follows detect comparator; adapter loss forces idle.
// RULE2: Device reset also resets the charger state machine.
// RULE3: Adapter and low battery enter precharge; set active and trickle.
// RULE4: Precharge limits current to the precharge selection.
// RULE5: Precharge past lockout enters constant current and pulses power-up.
// RULE6: Constant current needs charge enable; charge enable resets to one.
// RULE7: Constant current sets active and limits to fast selection.
// RULE8: Cutoff select picks 4.20 V or 4.10 V termination level.
// RULE9: Termination trip in constant current enters constant voltage phase.
// RULE10: Current at precharge level in constant voltage ends the charge.
// RULE11: Entering end of charge starts the missing battery timer.
// RULE12: Without inhibit, restart constant current 100 ms after restart.
// RULE13: Two consecutive timer reads under 2 s set battery absent.
// RULE14: Timer beyond 2 s after insertion clears battery absent.
// RULE15: Overvoltage select picks 6.05 V or 6.45 V; flag reads back.
// RULE16: Protected overvoltage clears charge enable and raises an interrupt.
// RULE17: Clearing charge enable clears end of charge and battery absent.
// RULE18: Fast code adds code times 50 mA to the precharge current.
// RULE19: Precharge codes 0 to 3 give 50, 100, 150, 200 mA.
// RULE20: All comparator inputs pass two flip-flops before use.
// RULE21: Restart delay and absent window count millisecond ticks.
module li_battery_charge_sequencer #(
  parameter int MS_CYCLES = charger_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Analog comparators
  input  wire charger_pkg::cmp_t    cmp_in,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  // Regulator and system
  output charger_pkg::reg_cmd_t     reg_cmd,
  output logic                      power_up_req,
  output logic                      irq
);

  localparam logic [11:0] RESTART_LAST =
    12'(charger_pkg::RESTART_DELAY_MS - 1);
  localparam logic [11:0] WINDOW_MS    = 12'(charger_pkg::ABSENT_WINDOW_MS);
  localparam logic [1:0]  REPEAT_LAST  = 2'(charger_pkg::ABSENT_REPEAT - 1);

  charger_pkg::cmp_t       cmp_meta_ff;
  charger_pkg::cmp_t       cmp_sync_ff;
  charger_pkg::chg_state_t state_ff;
  charger_pkg::chg_state_t nxt_state;
  logic                    charge_en_ff;
  logic [3:0]              fast_sel_ff;
  logic [1:0]              pre_sel_ff;
  logic                    ovp_en_ff;
  logic [1:0]              term_ofs_ff;
  logic                    inhibit_ff;
  logic                    cutoff_sel_ff;
  logic                    ovh_sel_ff;
  logic                    active_ff;
  logic                    trickle_ff;
  logic                    cv_ff;
  logic                    eoc_ff;
  logic                    absent_ff;
  logic [11:0]             restart_cnt_ff;
  logic [11:0]             absent_timer_ff;
  logic [1:0]              short_cnt_ff;
  logic                    resume_prev_ff;
  logic                    ov_trip_prev_ff;
  logic                    ms_tick;
  logic                    ov_trip;
  logic                    restart_evt;
  logic                    wr_ctrl_a;

  // RULE19 precharge current steps
  // Precharge current in mA for a two-bit code.
  function automatic logic [9:0] pre_ma(input logic [1:0] sel);
    pre_ma = charger_pkg::CURRENT_STEP_MA * 10'({8'h00, sel} + 10'h001);
  endfunction : pre_ma

  // Fast current in mA: precharge current plus code steps.
  function automatic logic [9:0] fast_ma(input logic [3:0] sel,
                                         input logic [1:0] pre);
    fast_ma = pre_ma(pre) + charger_pkg::CURRENT_STEP_MA * 10'({6'h00, sel});
  endfunction : fast_ma

  if (MS_CYCLES < 2) begin : g_bad_ms
    $error("MS_CYCLES must be at least two");
  end

  // RULE21 millisecond tick
  ms_tick_gen #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .clk   (clk),
    .rst   (rst),
    .clear (1'b0),
    .tick  (ms_tick)
  );

  // RULE20 two stage synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_meta_ff <= '0;
      cmp_sync_ff <= '0;
    end else begin
      cmp_meta_ff <= cmp_in;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  assign ov_trip     = cmp_sync_ff.overvolt && ovp_en_ff;
  assign restart_evt = cmp_sync_ff.batt_below_resume && !resume_prev_ff;
  assign wr_ctrl_a   = reg_wr && (reg_addr == charger_pkg::ADDR_CTRL_A);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      charger_pkg::ST_IDLE: begin
        // RULE3 precharge entry
        if (cmp_sync_ff.batt_below_uvlo) begin
          nxt_state = charger_pkg::ST_PRECHARGE;
        end else if (charge_en_ff) begin
          nxt_state = charger_pkg::ST_CONST_CURRENT;
        end
      end
      charger_pkg::ST_PRECHARGE: begin
        // RULE5 leave precharge
        if (!cmp_sync_ff.batt_below_uvlo) begin
          nxt_state = charge_en_ff ? charger_pkg::ST_CONST_CURRENT
                                   : charger_pkg::ST_IDLE;
        end
      end
      charger_pkg::ST_CONST_CURRENT: begin
        // RULE9 top-off entry
        if (cmp_sync_ff.at_termination) begin
          nxt_state = charger_pkg::ST_CONST_VOLTAGE;
        end
      end
      charger_pkg::ST_CONST_VOLTAGE: begin
        // RULE10 end of charge
        if (cmp_sync_ff.current_at_precharge) begin
          nxt_state = charger_pkg::ST_END_OF_CHARGE;
        end
      end
      charger_pkg::ST_END_OF_CHARGE: begin
        // RULE12 restart request
        if (restart_evt && !inhibit_ff) begin
          nxt_state = charger_pkg::ST_RESTART_WAIT;
        end
      end
      charger_pkg::ST_RESTART_WAIT: begin
        if (ms_tick && (restart_cnt_ff == RESTART_LAST)) begin
          nxt_state = charger_pkg::ST_CONST_CURRENT;
        end
      end
      default: nxt_state = charger_pkg::ST_IDLE;
    endcase
    // RULE6 charging needs enable
    if (!charge_en_ff && (nxt_state != charger_pkg::ST_PRECHARGE)) begin
      nxt_state = charger_pkg::ST_IDLE;
    end
    // RULE1 adapter loss
    if (!cmp_sync_ff.adapter_present) begin
      nxt_state = charger_pkg::ST_IDLE;
    end
  end

  // RULE2 reset to idle
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= charger_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // RULE16 overvoltage shutdown
  always_ff @(posedge clk) begin
    if (rst) begin
      charge_en_ff <= charger_pkg::RST_CHARGE_EN;
    end else if (ov_trip) begin
      charge_en_ff <= 1'b0;
    end else if (wr_ctrl_a) begin
      charge_en_ff <= reg_wdata[charger_pkg::CTRL_A_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fast_sel_ff <= charger_pkg::RST_FAST_SEL;
      pre_sel_ff  <= charger_pkg::RST_PRE_SEL;
      ovp_en_ff   <= charger_pkg::RST_OVP_EN;
    end else if (wr_ctrl_a) begin
      fast_sel_ff <= reg_wdata[charger_pkg::CTRL_A_FAST_LSB +: 4];
      pre_sel_ff  <= reg_wdata[charger_pkg::CTRL_A_PRE_LSB +: 2];
      ovp_en_ff   <= reg_wdata[charger_pkg::CTRL_A_OVP_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      term_ofs_ff   <= charger_pkg::RST_TERM_OFS;
      inhibit_ff    <= charger_pkg::RST_INHIBIT;
      cutoff_sel_ff <= charger_pkg::RST_CUTOFF_SEL;
      ovh_sel_ff    <= charger_pkg::RST_OVH_SEL;
    end else if (reg_wr) begin
      if (reg_addr == charger_pkg::ADDR_TERM_CFG) begin
        term_ofs_ff <= reg_wdata[charger_pkg::TERM_OFS_LSB +: 2];
      end
      if (reg_addr == charger_pkg::ADDR_CTRL_B) begin
        inhibit_ff    <= reg_wdata[charger_pkg::CTRL_B_INHIBIT];
        cutoff_sel_ff <= reg_wdata[charger_pkg::CTRL_B_CUTOFF];
        ovh_sel_ff    <= reg_wdata[charger_pkg::CTRL_B_OVH];
      end
    end
  end

  // Phase flags follow the next state so they line up with it.
  always_ff @(posedge clk) begin
    if (rst) begin
      active_ff  <= 1'b0;
      trickle_ff <= 1'b0;
      cv_ff      <= 1'b0;
    end else begin
      // RULE7 charging active
      active_ff  <= (nxt_state == charger_pkg::ST_PRECHARGE)
                 || (nxt_state == charger_pkg::ST_CONST_CURRENT)
                 || (nxt_state == charger_pkg::ST_CONST_VOLTAGE);
      trickle_ff <= (nxt_state == charger_pkg::ST_PRECHARGE);
      cv_ff      <= (nxt_state == charger_pkg::ST_CONST_VOLTAGE);
    end
  end

  // RULE17 end of charge flag
  always_ff @(posedge clk) begin
    if (rst) begin
      eoc_ff <= 1'b0;
    end else if (nxt_state == charger_pkg::ST_END_OF_CHARGE) begin
      eoc_ff <= 1'b1;
    end else if (!charge_en_ff) begin
      eoc_ff <= 1'b0;
    end
  end

  // RULE11 missing battery timer
  always_ff @(posedge clk) begin
    if (rst) begin
      absent_timer_ff <= '0;
    end else if (state_ff != charger_pkg::ST_END_OF_CHARGE) begin
      absent_timer_ff <= '0;
    end else if (ms_tick && (absent_timer_ff <= WINDOW_MS)) begin
      absent_timer_ff <= absent_timer_ff + 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      resume_prev_ff <= 1'b0;
    end else begin
      resume_prev_ff <= cmp_sync_ff.batt_below_resume;
    end
  end

  // RULE13 count short end of charge periods
  always_ff @(posedge clk) begin
    if (rst || !charge_en_ff) begin
      short_cnt_ff <= '0;
    end else if (state_ff == charger_pkg::ST_END_OF_CHARGE) begin
      if (absent_timer_ff > WINDOW_MS) begin
        short_cnt_ff <= '0;
      end else if (restart_evt && (short_cnt_ff != REPEAT_LAST + 2'h1)) begin
        short_cnt_ff <= short_cnt_ff + 2'h1;
      end
    end
  end

  // RULE14 battery absent flag
  always_ff @(posedge clk) begin
    if (rst) begin
      absent_ff <= 1'b0;
    end else if (state_ff == charger_pkg::ST_END_OF_CHARGE && restart_evt
                 && absent_timer_ff < WINDOW_MS
                 && short_cnt_ff >= REPEAT_LAST) begin
      absent_ff <= 1'b1;
    end else if (!charge_en_ff || absent_timer_ff > WINDOW_MS) begin
      absent_ff <= 1'b0;
    end
  end

  // RULE12 restart dead time
  always_ff @(posedge clk) begin
    if (rst || state_ff != charger_pkg::ST_RESTART_WAIT) begin
      restart_cnt_ff <= '0;
    end else if (ms_tick) begin
      restart_cnt_ff <= restart_cnt_ff + 12'h001;
    end
  end

  // RULE5 power-up pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      power_up_req <= 1'b0;
    end else begin
      power_up_req <= (state_ff == charger_pkg::ST_PRECHARGE)
                   && (nxt_state == charger_pkg::ST_CONST_CURRENT);
    end
  end

  // RULE16 overvoltage interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      ov_trip_prev_ff <= 1'b0;
      irq             <= 1'b0;
    end else begin
      ov_trip_prev_ff <= ov_trip;
      irq             <= ov_trip && !ov_trip_prev_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_cmd <= '0;
    end else begin
      // RULE4 precharge limit
      if (nxt_state == charger_pkg::ST_PRECHARGE) begin
        reg_cmd.current_limit_ma <= pre_ma(pre_sel_ff);
      end else begin
        // RULE18 fast current limit
        reg_cmd.current_limit_ma <= fast_ma(fast_sel_ff, pre_sel_ff);
      end
      reg_cmd.regulate_on   <= (nxt_state == charger_pkg::ST_PRECHARGE)
                            || (nxt_state == charger_pkg::ST_CONST_CURRENT)
                            || (nxt_state == charger_pkg::ST_CONST_VOLTAGE);
      reg_cmd.const_voltage <= (nxt_state == charger_pkg::ST_CONST_VOLTAGE);
      // RULE8 termination level select
      reg_cmd.cutoff_voltage_sel   <= cutoff_sel_ff;
      // RULE15 overvoltage threshold select
      reg_cmd.overvolt_high_thresh <= ovh_sel_ff;
      reg_cmd.termination_current_offset <= term_ofs_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        charger_pkg::ADDR_TERM_CFG: reg_rdata <= {4'h0, term_ofs_ff, 2'h0};
        charger_pkg::ADDR_CTRL_A:
          reg_rdata <= {ovp_en_ff, pre_sel_ff, fast_sel_ff, charge_en_ff};
        charger_pkg::ADDR_CTRL_B:
          reg_rdata <= {cmp_sync_ff.overvolt, ovh_sel_ff, 1'b0,
                        cutoff_sel_ff, inhibit_ff, 3'h0};
        charger_pkg::ADDR_STATUS:
          reg_rdata <= {1'b0, absent_ff, eoc_ff, cv_ff, trickle_ff, 1'b0,
                        active_ff, cmp_sync_ff.adapter_present};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_adapter_loss_idle: assert property ( // RULE1
    !cmp_sync_ff.adapter_present |=> state_ff == charger_pkg::ST_IDLE)
    else $error("adapter loss did not return to idle");
  chk_reset_idle: assert property (disable iff (1'b0) // RULE2
    rst |=> state_ff == charger_pkg::ST_IDLE)
    else $error("reset did not clear charger state");
  chk_precharge_flags: assert property ( // RULE3
    state_ff == charger_pkg::ST_PRECHARGE |-> active_ff && trickle_ff)
    else $error("precharge flags missing");
  chk_precharge_limit: assert property ( // RULE4
    state_ff == charger_pkg::ST_PRECHARGE && $stable(pre_sel_ff)
    |-> reg_cmd.current_limit_ma == pre_ma(pre_sel_ff))
    else $error("precharge current limit wrong");
  chk_power_up_pulse: assert property ( // RULE5
    state_ff == charger_pkg::ST_PRECHARGE
    ##1 state_ff == charger_pkg::ST_CONST_CURRENT
    |-> power_up_req && !trickle_ff)
    else $error("no power-up on leaving precharge");
  chk_cc_needs_enable: assert property ( // RULE6
    $rose(state_ff == charger_pkg::ST_CONST_CURRENT) |-> $past(charge_en_ff))
    else $error("constant current began without enable");
  chk_cv_entry: assert property ( // RULE9
    state_ff == charger_pkg::ST_CONST_CURRENT && cmp_sync_ff.at_termination
    && cmp_sync_ff.adapter_present && charge_en_ff
    |=> state_ff == charger_pkg::ST_CONST_VOLTAGE && cv_ff)
    else $error("termination trip did not enter top-off");
  chk_restart_delay: assert property ( // RULE12
    state_ff == charger_pkg::ST_RESTART_WAIT
    ##1 state_ff == charger_pkg::ST_CONST_CURRENT
    |-> $past(restart_cnt_ff) == RESTART_LAST)
    else $error("restart dead time wrong");
  chk_absent_set: assert property ( // RULE13
    $rose(absent_ff) |-> $past(short_cnt_ff) == REPEAT_LAST)
    else $error("battery absent set too early");
  chk_ov_shutdown: assert property ( // RULE16
    ov_trip && !ov_trip_prev_ff |=> !charge_en_ff && irq)
    else $error("overvoltage did not shut down");

  cov_precharge_to_cc: cover property (
    state_ff == charger_pkg::ST_PRECHARGE
    ##1 state_ff == charger_pkg::ST_CONST_CURRENT);
  cov_end_of_charge: cover property ($rose(eoc_ff));
  cov_absent: cover property ($rose(absent_ff));
  cov_restart: cover property (
    state_ff == charger_pkg::ST_RESTART_WAIT
    ##1 state_ff == charger_pkg::ST_CONST_CURRENT);

endmodule : li_battery_charge_sequencer

// ### verification/charge_source_model.sv
// Purpose: Adapter and battery as the charger comparators see them.
// Assumes: The bench sets adapter and battery voltages in mV.
// Notes:   Taper current reaches precharge level after CV_CYCLES.
`timescale 1ns/10ps
module charge_source_model #(
  parameter int CV_CYCLES = 20
) (
  // Clock
  input  wire logic                  clk,
  // Regulator command
  input  wire charger_pkg::reg_cmd_t cmd,
  // Comparator results
  output charger_pkg::cmp_t          cmp
);
  int adapter_mv = 0;
  int batt_mv    = 2500;
  int cv_cnt     = 0;

  // The charge current tapers off while voltage is held.
  always_ff @(posedge clk) begin
    cv_cnt <= cmd.const_voltage ? cv_cnt + 1 : 0;
  end

  always_comb begin
    cmp.adapter_present      = adapter_mv > batt_mv + 75;
    cmp.batt_below_uvlo      = batt_mv < 2800;
    cmp.at_termination       =
      batt_mv >= (cmd.cutoff_voltage_sel ? 4200 : 4100);
    cmp.current_at_precharge = cv_cnt >= CV_CYCLES;
    cmp.batt_below_resume    =
      batt_mv < (cmd.cutoff_voltage_sel ? 3850 : 3750);
    cmp.overvolt             =
      adapter_mv > (cmd.overvolt_high_thresh ? 6450 : 6050);
  end
endmodule : charge_source_model

// ### verification/li_battery_charge_sequencer_test.sv
// Purpose: Self-checking bench of the charge sequencer.
// Assumes: One millisecond is shortened to ten core clocks.
// Notes:   Registers are reached over the internal byte port.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module li_battery_charge_sequencer_test;
  localparam int MS = 10;
  localparam logic [7:0] A = charger_pkg::ADDR_CTRL_A;
  localparam logic [7:0] B = charger_pkg::ADDR_CTRL_B;
  localparam logic [7:0] S = charger_pkg::ADDR_STATUS;
  localparam logic [7:0] T = charger_pkg::ADDR_TERM_CFG;
  logic                  clk       = 1'b0;
  logic                  rst       = 1'b1;
  logic [7:0]            reg_addr  = 8'h00;
  logic [7:0]            reg_wdata = 8'h00;
  logic                  reg_wr    = 1'b0;
  logic                  reg_rd    = 1'b0;
  logic [7:0]            reg_rdata;
  charger_pkg::cmp_t     cmp;
  charger_pkg::reg_cmd_t cmd;
  logic                  power_up_req;
  logic                  irq;
  int                    fails     = 0;
  int                    n_checks  = 0;
  int                    irq_n     = 0;
  int                    pu_n      = 0;

  li_battery_charge_sequencer #(.MS_CYCLES(MS)) uut (
    .clk(clk), .rst(rst), .cmp_in(cmp), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_cmd(cmd), .power_up_req(power_up_req),
    .irq(irq));
  charge_source_model m (.clk(clk), .cmd(cmd), .cmp(cmp));

  initial begin
    forever #5 clk = ~clk;
  end

  // Pulses are counted so that no single cycle can be missed.
  always @(posedge clk) begin
    if (irq === 1'b1) irq_n++;
    if (power_up_req === 1'b1) pu_n++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic volt(input int a, input int b);
    @(posedge clk);
    m.adapter_mv <= a;
    m.batt_mv    <= b;
  endtask : volt

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] k = 8'hFF);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    #1 `CHK(reg_rdata & k, e)
  endtask : rd

  function automatic logic [9:0] lim(input int p, input int f);
    return 10'(50 * (p + 1 + f));
  endfunction : lim

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial begin
    #400_000;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(A, 8'h81);
    rd(B, 8'h50);
    rd(S, 8'h00);
    rd(8'h20, 8'h00);
    wr(B, 8'hFF);
    rd(B, 8'h58);
    wr(T, 8'hFF);
    rd(T, 8'h0C);
    `CHK(cmd.termination_current_offset, 2'h3)
    wr(T, 8'h00);
    wr(B, 8'h50);
    volt(5000, 2500);
    cyc(6);
    rd(S, 8'h0B);
    for (int p = 0; p < 4; p++) begin
      wr(A, 8'h9F | 8'(p << 5));
      cyc(3);
      `CHK(cmd.current_limit_ma, lim(p, 0))
    end
    volt(5000, 3500);
    cyc(6);
    `CHK(pu_n, 1)
    rd(S, 8'h03);
    for (int f = 0; f < 16; f++) begin
      wr(A, 8'hE1 | 8'(f << 1));
      cyc(3);
      `CHK(cmd.current_limit_ma, lim(3, f))
    end
    volt(5000, 4150);
    cyc(6);
    `CHK(cmd.const_voltage, 1'b0)
    wr(B, 8'h40);
    cyc(5);
    rd(S, 8'h13);
    cyc(30);
    rd(S, 8'h20, 8'h30);
    volt(5000, 3600);
    cyc(90 * MS);
    `CHK(cmd.regulate_on, 1'b0)
    cyc(13 * MS);
    `CHK(cmd.regulate_on, 1'b1)
    rd(S, 8'h00, 8'h40);
    volt(5000, 4150);
    cyc(40);
    volt(5000, 3600);
    cyc(6);
    rd(S, 8'h40, 8'h40);
    cyc(103 * MS);
    volt(5000, 4150);
    cyc(40);
    rd(S, 8'h40, 8'h40);
    cyc(2002 * MS);
    rd(S, 8'h20, 8'h60);
    wr(B, 8'h48);
    volt(5000, 3600);
    cyc(103 * MS);
    `CHK(cmd.regulate_on, 1'b0)
    volt(6200, 3600);
    cyc(6);
    rd(B, 8'h48);
    `CHK(irq_n, 0)
    wr(B, 8'h08);
    cyc(6);
    rd(B, 8'h88);
    `CHK(irq_n, 1)
    rd(A, 8'hFE);
    rd(S, 8'h01);
    volt(0, 3600);
    cyc(6);
    rd(S, 8'h00);
    wr(B, 8'h50);
    wr(A, 8'hE5);
    volt(5000, 3600);
    cyc(6);
    rd(S, 8'h03);
    @(posedge clk) rst <= 1'b1;
    cyc(3);
    `CHK(cmd.regulate_on, 1'b0)
    @(posedge clk) rst <= 1'b0;
    rd(A, 8'h81);
    wrap_up();
  end
endmodule : li_battery_charge_sequencer_test
